/* File: logic/cldsl_top.sv */
`timescale 1ns/1ps
`default_nettype none

module cldsl_fifo #(
	parameter int unsigned W = 25,
	parameter int unsigned DEPTH = 4
) (
	input wire logic clk,
	input wire logic srst,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [W-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [W-1:0] out_data
);
	localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int unsigned CW = $clog2(DEPTH + 1);
	localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);
	localparam logic [CW-1:0] FULL = CW'(DEPTH);

	logic [W-1:0] mem_q [DEPTH];
	logic [AW-1:0] wr_q;
	logic [AW-1:0] rd_q;
	logic [CW-1:0] cnt_q;
	logic push;
	logic pop;

	function automatic logic [AW-1:0] nxt(input logic [AW-1:0] p);
		nxt = (p == LAST) ? '0 : p + AW'(1);
	endfunction

	assign in_ready = (cnt_q != FULL);
	assign out_valid = (cnt_q != '0);
	assign out_data = mem_q[rd_q];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	always_ff @(posedge clk) begin
		if (push) begin
			mem_q[wr_q] <= in_data;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			wr_q <= '0;
			rd_q <= '0;
			cnt_q <= '0;
		end else begin
			if (push) begin
				wr_q <= nxt(wr_q);
			end
			if (pop) begin
				rd_q <= nxt(rd_q);
			end
			if (push && !pop) begin
				cnt_q <= cnt_q + CW'(1);
			end else if (pop && !push) begin
				cnt_q <= cnt_q - CW'(1);
			end
		end
	end
endmodule

module cldsl_top (
	input wire logic clk,
	input wire logic srst,
	input wire logic sclk_pin,
	input wire logic din_pin,
	input wire logic enable_n_pin,
	output logic dout,
	output logic [cldsl_pkg::CFG_W-1:0] cfg_reg,
	output logic [cldsl_pkg::SR_W-1:0] disp_reg,
	output logic lamp_ctrl_bit_a,
	output logic lamp_ctrl_bit_b,
	output logic lamp_ctrl_bit_c,
	output logic lamp_bank1_on,
	output logic lamp_bank2_on,
	output logic upd_valid,
	input wire logic upd_ready,
	output logic upd_is_disp,
	output logic [cldsl_pkg::SR_W-1:0] upd_data
);
	logic [2:0] sync0_q;
	logic [2:0] sync1_q;
	logic [2:0] sync2_q;
	logic [2:0] filt_q;
	logic [2:0] prev_q;
	logic sclk_rise;
	logic sclk_fall;
	logic en_rise;
	logic en_fall;
	logic active;
	logic [cldsl_pkg::SR_W-1:0] sr_q;
	logic [cldsl_pkg::CNT_W-1:0] cnt_q;
	logic pend_q;
	logic [cldsl_pkg::FIFO_W-1:0] pend_data_q;
	logic commit;
	logic take;
	logic push;
	logic fifo_in_ready;
	logic [cldsl_pkg::FIFO_W-1:0] fifo_out;

	// Length decides the target register, also used by the cover points
	function automatic logic is_disp(input logic [cldsl_pkg::CNT_W-1:0] n);
		is_disp = n[cldsl_pkg::CNT_DISP_BIT];
	endfunction

	// Filter passes a level only once the last two stages agree
	always_ff @(posedge clk) begin
		if (srst) begin
			sync0_q <= cldsl_pkg::PIN_RST;
			sync1_q <= cldsl_pkg::PIN_RST;
			sync2_q <= cldsl_pkg::PIN_RST;
			filt_q <= cldsl_pkg::PIN_RST;
			prev_q <= cldsl_pkg::PIN_RST;
		end else begin
			sync0_q <= {enable_n_pin, din_pin, sclk_pin};
			sync1_q <= sync0_q;
			sync2_q <= sync1_q;
			filt_q <= (sync1_q & sync2_q) | (filt_q & (sync1_q ^ sync2_q));
			prev_q <= filt_q;
		end
	end

	assign sclk_rise = filt_q[cldsl_pkg::PIN_SCLK] && !prev_q[cldsl_pkg::PIN_SCLK];
	assign sclk_fall = !filt_q[cldsl_pkg::PIN_SCLK] && prev_q[cldsl_pkg::PIN_SCLK];
	assign en_rise = filt_q[cldsl_pkg::PIN_EN_N] && !prev_q[cldsl_pkg::PIN_EN_N];
	assign en_fall = !filt_q[cldsl_pkg::PIN_EN_N] && prev_q[cldsl_pkg::PIN_EN_N];
	assign active = !filt_q[cldsl_pkg::PIN_EN_N];

	// Bits are shifted and counted only while enable is low
	always_ff @(posedge clk) begin
		if (srst) begin
			sr_q <= cldsl_pkg::SR_RST;
			cnt_q <= cldsl_pkg::CNT_RST;
		end else begin
			if (sclk_rise && active) begin
				sr_q <= {sr_q[cldsl_pkg::SR_W-2:0], filt_q[cldsl_pkg::PIN_DIN]};
			end
			if (en_rise || en_fall) begin
				cnt_q <= cldsl_pkg::CNT_RST;
			end else if (sclk_rise && active && cnt_q != cldsl_pkg::CNT_MAX) begin
				cnt_q <= cnt_q + 16'h0001;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			dout <= 1'h0;
		end else if (sclk_fall && active) begin
			dout <= sr_q[cldsl_pkg::SR_W-1];
		end
	end

	assign commit = en_rise && (cnt_q >= cldsl_pkg::CNT_MIN_BITS);
	assign push = pend_q && fifo_in_ready;
	// A full queue holds the commit; a second one meanwhile is dropped
	assign take = commit && (!pend_q || push);

	always_ff @(posedge clk) begin
		if (srst) begin
			pend_q <= 1'h0;
			pend_data_q <= {1'h0, cldsl_pkg::SR_RST};
		end else begin
			if (push) begin
				pend_q <= 1'h0;
			end
			if (take) begin
				pend_q <= 1'h1;
				if (is_disp(cnt_q)) begin
					pend_data_q <= {1'h1, sr_q};
				end else begin
					pend_data_q <= {1'h0, 16'h0000, sr_q[cldsl_pkg::CFG_W-1:0]};
				end
			end
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			cfg_reg <= cldsl_pkg::CFG_RST;
			disp_reg <= cldsl_pkg::DISP_RST;
			lamp_bank1_on <= 1'h0;
			lamp_bank2_on <= 1'h0;
		end else if (push) begin
			if (pend_data_q[cldsl_pkg::SR_W]) begin
				disp_reg <= pend_data_q[cldsl_pkg::SR_W-1:0];
				lamp_bank1_on <= pend_data_q[cldsl_pkg::LAMP_A_POS]
					| pend_data_q[cldsl_pkg::LAMP_C_POS];
				lamp_bank2_on <= pend_data_q[cldsl_pkg::LAMP_B_POS]
					| pend_data_q[cldsl_pkg::LAMP_C_POS];
			end else begin
				cfg_reg <= pend_data_q[cldsl_pkg::CFG_W-1:0];
			end
		end
	end

	assign lamp_ctrl_bit_a = disp_reg[cldsl_pkg::LAMP_A_POS];
	assign lamp_ctrl_bit_b = disp_reg[cldsl_pkg::LAMP_B_POS];
	assign lamp_ctrl_bit_c = disp_reg[cldsl_pkg::LAMP_C_POS];

	cldsl_fifo #(
		.W(cldsl_pkg::FIFO_W),
		.DEPTH(cldsl_pkg::FIFO_DEPTH)
	) u_fifo (
		.clk(clk),
		.srst(srst),
		.in_valid(pend_q),
		.in_ready(fifo_in_ready),
		.in_data(pend_data_q),
		.out_valid(upd_valid),
		.out_ready(upd_ready),
		.out_data(fifo_out)
	);

	assign upd_is_disp = fifo_out[cldsl_pkg::SR_W];
	assign upd_data = fifo_out[cldsl_pkg::SR_W-1:0];

	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);

	dout_shift_a: assert property (sclk_fall && active |=> dout == $past(sr_q[23]))
		else $error("serial out did not follow shift register msb");
	dout_hold_a: assert property (!(sclk_fall && active) |=> $stable(dout))
		else $error("serial out changed without falling clock");
	idle_hold_a: assert property (!active |=> $stable(sr_q))
		else $error("shift register moved while enable high");
	cfg_commit_a: assert property (take && cnt_q == 16'h0020 |=>
		pend_q && !pend_data_q[24] && pend_data_q[7:0] == $past(sr_q[7:0]))
		else $error("config commit wrong after 32 bits");
	disp_commit_a: assert property (take && cnt_q == 16'h0030 |=>
		pend_q && pend_data_q == {1'h1, $past(sr_q)})
		else $error("display commit wrong after 48 bits");
	three_dev_a: assert property (take && (cnt_q == 16'h0040 || cnt_q == 16'h0050) |=>
		pend_data_q[24] == ($past(cnt_q) == 16'h0050))
		else $error("three device commit picked wrong register");
	six_dev_a: assert property (take && (cnt_q == 16'h0080 || cnt_q == 16'h0090) |=>
		pend_data_q[24] == ($past(cnt_q) == 16'h0090))
		else $error("six device commit picked wrong register");
	lamp_map_a: assert property (push && pend_data_q[24] |=>
		lamp_bank1_on == ($past(pend_data_q[20]) | $past(pend_data_q[22]))
		&& lamp_bank2_on == ($past(pend_data_q[21]) | $past(pend_data_q[22])))
		else $error("lamp outputs do not follow display bits");
	cfg_apply_a: assert property (push && !pend_data_q[24] |=>
		cfg_reg == $past(pend_data_q[7:0]) && $stable(disp_reg))
		else $error("config register not applied");

	cfg_seen_c: cover property (take && !is_disp(cnt_q));
	disp_seen_c: cover property (take && is_disp(cnt_q));
	split_upd_c: cover property (take && cnt_q == 16'h0030 ##[1:400] take && cnt_q == 16'h0018);
	fifo_full_c: cover property (pend_q && !fifo_in_ready);
endmodule
`default_nettype wire

/* File: pkg/cldsl_pkg.sv */
`default_nettype none
package cldsl_pkg;
	localparam int unsigned SR_W = 24;
	localparam int unsigned CFG_W = 8;
	localparam int unsigned CNT_W = 16;
	localparam int unsigned FIFO_DEPTH = 4;
	localparam int unsigned FIFO_W = SR_W + 1;
	// Pin bit positions inside the synchroniser vectors
	localparam int unsigned PIN_SCLK = 0;
	localparam int unsigned PIN_DIN = 1;
	localparam int unsigned PIN_EN_N = 2;
	localparam logic [2:0] PIN_RST = 3'h4;
	// Lamp control bit positions in the display word
	localparam int unsigned LAMP_A_POS = 20;
	localparam int unsigned LAMP_B_POS = 21;
	localparam int unsigned LAMP_C_POS = 22;
	// Bit of the transfer length that marks a display transfer
	localparam int unsigned CNT_DISP_BIT = 4;
	localparam logic [CNT_W-1:0] CNT_MIN_BITS = 16'h0008;
	localparam logic [CNT_W-1:0] CNT_MAX = 16'hffff;
	localparam logic [CNT_W-1:0] CNT_RST = 16'h0000;
	localparam logic [SR_W-1:0] SR_RST = 24'h000000;
	localparam logic [SR_W-1:0] DISP_RST = 24'h000000;
	localparam logic [CFG_W-1:0] CFG_RST = 8'h00;
endpackage
`default_nettype wire

/* File: verif/cldsl_host.sv */
`timescale 1ns/1ps
`default_nettype none
module cldsl_host (
	input wire logic clk,
	output logic sclk_pin,
	output logic din_pin,
	output logic enable_n_pin
);
	// Serial clock stands low between frames
	initial begin
		sclk_pin = 1'h0;
		din_pin = 1'h0;
		enable_n_pin = 1'h1;
	end
	task automatic wt(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic frame(input logic [143:0] v, input int nb, input int gap);
		enable_n_pin <= 1'h0;
		wt(6);
		for (int i = nb - 1; i >= 0; i--) begin
			din_pin <= v[i];
			wt(6);
			sclk_pin <= 1'h1;
			wt(6);
			sclk_pin <= 1'h0;
		end
		wt(6);
		enable_n_pin <= 1'h1;
		din_pin <= ~din_pin;
		wt(gap);
	endtask
endmodule
`default_nettype wire

/* File: verif/test_cldsl_top.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin errors++; \
	$display("[ERR] %s exp %h got %h", nm, e, g); end end
module test_cldsl_top;
	logic clk, srst, sclk_pin, din_pin, enable_n_pin, dout, upd_ready, upd_valid, upd_is_disp;
	logic la, lb, lc, b1, b2;
	logic [cldsl_pkg::CFG_W-1:0] cfg_reg;
	logic [cldsl_pkg::SR_W-1:0] disp_reg, upd_data;
	logic [24:0] exp_q[$];
	logic [24:0] w_exp;
	int errors = 0;
	int n_checks = 0;
	int cyc = 0;
	cldsl_host host (.clk(clk), .sclk_pin(sclk_pin), .din_pin(din_pin),
		.enable_n_pin(enable_n_pin));
	cldsl_top dut (.clk(clk), .srst(srst), .sclk_pin(sclk_pin), .din_pin(din_pin),
		.enable_n_pin(enable_n_pin), .dout(dout), .cfg_reg(cfg_reg), .disp_reg(disp_reg),
		.lamp_ctrl_bit_a(la), .lamp_ctrl_bit_b(lb), .lamp_ctrl_bit_c(lc),
		.lamp_bank1_on(b1), .lamp_bank2_on(b2), .upd_valid(upd_valid),
		.upd_ready(upd_ready), .upd_is_disp(upd_is_disp), .upd_data(upd_data));
	initial begin
		clk = 1'h0;
		forever #12.5 clk = ~clk;
	end
	task automatic report_and_stop;
		if (errors == 0 && n_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// Hang guard well above the full run
	always @(posedge clk) begin
		cyc++;
		if (cyc > 30000) begin
			errors++;
			report_and_stop();
		end
	end
	always @(posedge clk) begin
		if (!srst && upd_valid === 1'h1 && upd_ready) begin
			w_exp = exp_q.size() > 0 ? exp_q.pop_front() : 25'h1ffffff;
			`CHK("upd_word", w_exp, {upd_is_disp, upd_data})
		end
	end
	task automatic xfer(input logic [143:0] v, input int nb, input bit disp);
		exp_q.push_back(disp ? {1'h1, v[23:0]} : {17'h0, v[7:0]});
		host.frame(v, nb, 14);
		if (disp) begin
			`CHK("disp_reg", v[23:0], disp_reg)
			`CHK("lamps", {v[22:20], v[20] | v[22], v[21] | v[22]}, {lc, lb, la, b1, b2})
		end else begin
			`CHK("cfg_reg", v[7:0], cfg_reg)
		end
		if (nb >= 24)
			`CHK("dout", v[23], dout)
	endtask
	task automatic t_reset;
		`CHK("reset", 39'h0, {dout, cfg_reg, disp_reg, upd_valid, la, lb, lc, b1, b2})
	endtask
	// Lengths for one to six devices, config and display alternating
	task automatic t_chain;
		int nbs[12] = '{8, 24, 32, 48, 64, 80, 96, 112, 104, 120, 128, 144};
		for (int i = 0; i < 12; i++)
			xfer(({6{24'h3c5a96}} << i) ^ 144'(i * 37), nbs[i], i[0]);
	endtask
	task automatic t_split;
		xfer({6{24'h71e4b2}}, 48, 1'h1);
		xfer({6{24'h4d2c19}}, 24, 1'h1);
	endtask
	task automatic t_short;
		logic [7:0] keep;
		keep = cfg_reg;
		host.frame(144'h5, 4, 14);
		`CHK("short_cfg", keep, cfg_reg)
		`CHK("short_valid", 1'h0, upd_valid)
	endtask
	// Fill the queue until a commit waits, then drain
	task automatic t_fifo;
		upd_ready <= 1'h0;
		for (int k = 0; k < 5; k++) begin
			exp_q.push_back({17'h0, 8'h90 + 8'(k)});
			host.frame(144'h90 + 144'(k), 8, 14);
		end
		`CHK("full_valid", 1'h1, upd_valid)
		`CHK("full_cfg", 8'h93, cfg_reg)
		upd_ready <= 1'h1;
		repeat (20) @(posedge clk);
		`CHK("drain_cfg", 8'h94, cfg_reg)
		`CHK("drain_valid", 1'h0, upd_valid)
	endtask
	initial begin
		srst = 1'h1;
		upd_ready = 1'h1;
		repeat (3) @(posedge clk);
		srst <= 1'h0;
		repeat (6) @(posedge clk);
		t_reset();
		t_chain();
		t_split();
		t_short();
		t_fifo();
		`CHK("left", 0, exp_q.size())
		report_and_stop();
	end
endmodule
`default_nettype wire
